/* logic/rfsc_core.sv */
`timescale 1ns/1ps
// Behaviour
// R1 - Pin control and serial registers both steer one shared state machine.
// R2 - Active pin low keeps the front-end in power-down.
// R3 - Active pin high moves power-down to program state.
// R4 - Every program-state entry reloads configuration registers with reset values.
// R5 - Pin mode: active, receive and transmit request pins pick the state.
// R6 - Receive state: receive path and low-noise amplifier on, transmit off.
// R7 - Transmit state: transmit path and power amplifier on, receive off.
// R8 - Serial mode: transmit and receive control register bits pick the state.
// R9 - Efuse state entered only from program state by a keyed receive-control write.
// R10 - Two efuse registers define the bit and trigger one-time programming.
// R11 - Transmit control register reachable in program, receive, transmit, efuse states.
// R12 - Receive control register reachable in program, receive, transmit, efuse states.
// R13 - Efuse interface registers reachable only in efuse state.
// R14 - Part code, revision and identity registers readable only in program state.
// R15 - Efuse state stores both preset selectors and both preset gains.
// R16 - Power-down, program and efuse states isolate both antenna ports.
// R17 - Receive or transmit with antenna pin low: first port on, second off.
// R18 - Receive or transmit with antenna pin high: first port off, second on.
// R19 - Mode bit in transmit control selects efuse custom presets as gain.
// R20 - Host keeps nine lines dedicated to front-end control.
// R21 - Host never requests receive and transmit together.
module rfsc_core #(
    parameter logic [7:0] PART_CODE = 8'h5A,  // Arbitrary value
    parameter logic [3:0] SILICON_REV = 4'h1, // Arbitrary value
    parameter logic [7:0] HW_ID_LOW = 8'h3C,  // Arbitrary value
    parameter logic [7:0] HW_ID_HIGH = 8'hC3  // Arbitrary value
) (
    input  logic                 clock,
    input  logic                 reset,
    input  logic                 fem_active_pin,
    input  logic                 rx_request_pin,
    input  logic                 tx_request_pin,
    input  logic                 mode_pin,
    input  logic                 antenna_choice_pin,
    input  logic                 spi_sck,
    input  logic                 spi_csn,
    input  logic                 spi_mosi,
    output logic                 spi_miso,
    output logic                 spi_miso_oe,
    output logic                 rx_path_en,
    output logic                 lna_en,
    output logic                 tx_path_en,
    output logic                 pa_en,
    output logic                 first_antenna_port,
    output logic                 second_antenna_port,
    output logic [4:0]           tx_gain,
    output logic                 efuse_burn,
    output rfsc_pkg::rfsc_state_t fem_state
);
    import rfsc_pkg::*;

    logic [7:0]  pins_raw;
    logic [7:0]  lv;
    logic        sck_lv, csn_lv, mosi_lv, act_lv, rx_lv, tx_lv, ant_lv, mode_lv;

    // Outside pins through the three-stage filter
    assign pins_raw = {mode_pin, antenna_choice_pin, tx_request_pin, rx_request_pin,
                       fem_active_pin, spi_mosi, spi_csn, spi_sck};
    rfsc_sync3 #(.WIDTH(8)) u_sync (
        .clock    (clock),
        .reset    (reset),
        .async_in (pins_raw),
        .level    (lv)
    );
    assign {mode_lv, ant_lv, tx_lv, rx_lv, act_lv, mosi_lv, csn_lv, sck_lv} = lv;

    rfsc_state_t state_r, state_nxt;
    logic [7:0]  tx_ctrl_r, tx_ctrl_nxt;
    logic [7:0]  rx_ctrl_r, rx_ctrl_nxt;
    logic [7:0]  ef_def_r, ef_def_nxt;
    logic [FUSE_W-1:0] fuse_r, fuse_nxt;
    logic        burn_r, burn_nxt;
    logic        sck_prev_r, sck_prev_nxt;
    logic [4:0]  bit_cnt_r, bit_cnt_nxt;
    logic [15:0] shift_r, shift_nxt;
    logic [7:0]  rd_sh_r, rd_sh_nxt;
    logic        miso_r, miso_nxt;
    logic        miso_oe_r, miso_oe_nxt;
    logic        rxp_r, rxp_nxt, txp_r, txp_nxt;
    logic        port1_r, port1_nxt, port2_r, port2_nxt;
    logic [4:0]  gain_r, gain_nxt;
    logic        sck_rise, sck_fall, spi_live;
    logic        wr_stb;
    logic [6:0]  wr_addr, rd_addr;
    logic [7:0]  wr_data, rd_val;
    logic        acc_cfg, acc_ef, acc_id;
    logic        rx_req, tx_req, key_hit, prog_entry, pout_b;

    // Access windows by state
    assign acc_cfg = (state_r != ST_OFF);                        // [R11] [R12]
    assign acc_ef  = (state_r == ST_EFUSE);                      // [R13]
    assign acc_id  = (state_r == ST_PROG);                       // [R14]

    // Read multiplexer, gated by access window
    always_comb begin
        rd_addr = {shift_r[5:0], mosi_lv};
        rd_val  = 8'h00;
        case (rd_addr)
            ADDR_TX_CTRL: rd_val = acc_cfg ? tx_ctrl_r : 8'h00;  // [R11]
            ADDR_RX_CTRL: rd_val = acc_cfg ? rx_ctrl_r : 8'h00;  // [R12]
            ADDR_EF_DEF:  rd_val = acc_ef ? ef_def_r : 8'h00;    // [R13]
            ADDR_PART:    rd_val = acc_id ? PART_CODE : 8'h00;   // [R14]
            ADDR_ID_LOW:  rd_val = acc_id ? HW_ID_LOW : 8'h00;   // [R14]
            ADDR_ID_HIGH: rd_val = acc_id ? {SILICON_REV, HW_ID_HIGH[3:0]} : 8'h00; // [R14]
            default:      rd_val = 8'h00;
        endcase
    end

    // Serial slave: sample on rising clock, shift out on falling clock
    always_comb begin
        sck_rise     = sck_lv & ~sck_prev_r;
        sck_fall     = ~sck_lv & sck_prev_r;
        spi_live     = ~csn_lv && (state_r != ST_OFF);
        sck_prev_nxt = sck_lv;
        bit_cnt_nxt  = bit_cnt_r;
        shift_nxt    = shift_r;
        rd_sh_nxt    = rd_sh_r;
        miso_nxt     = miso_r;
        miso_oe_nxt  = miso_oe_r;
        wr_stb       = 1'b0;
        wr_addr      = shift_r[13:7];
        wr_data      = {shift_r[6:0], mosi_lv};
        if (!spi_live) begin
            bit_cnt_nxt = 5'h00;
            miso_nxt    = 1'b0;
            miso_oe_nxt = 1'b0;
        end else begin
            miso_oe_nxt = 1'b1;
            if (sck_rise && bit_cnt_r < SPI_FRAME_BITS) begin
                shift_nxt   = {shift_r[14:0], mosi_lv};
                bit_cnt_nxt = bit_cnt_r + 5'h01;
                if (bit_cnt_r == SPI_HDR_BITS - 5'h01) begin
                    rd_sh_nxt = rd_val;
                end
                if (bit_cnt_r == SPI_FRAME_BITS - 5'h01) begin
                    wr_stb = shift_r[14];                       // [R8]
                end
            end
            if (sck_fall && bit_cnt_r >= SPI_HDR_BITS && bit_cnt_r < SPI_FRAME_BITS) begin
                miso_nxt  = rd_sh_r[7];
                rd_sh_nxt = {rd_sh_r[6:0], 1'b0};
            end
        end
    end

    // State selection from pins and register bits together
    always_comb begin
        rx_req  = rx_lv | rx_ctrl_r[RXC_ON_BIT];                 // [R1] [R5] [R8]
        tx_req  = tx_lv | tx_ctrl_r[TXC_ON_BIT];                 // [R1] [R5] [R8]
        key_hit = (rx_ctrl_r[RXC_KEY_MSB:RXC_KEY_LSB] == EFUSE_KEY);
        state_nxt = state_r;
        case (state_r)
            ST_OFF: begin
                state_nxt = ST_PROG;                             // [R3]
            end
            ST_PROG, ST_RX, ST_TX: begin
                if (state_r == ST_PROG && key_hit) begin
                    state_nxt = ST_EFUSE;                        // [R9]
                end else if (rx_req && !tx_req) begin
                    state_nxt = ST_RX;
                end else if (tx_req && !rx_req) begin
                    state_nxt = ST_TX;
                end else begin
                    state_nxt = ST_PROG;                         // [R21]
                end
            end
            ST_EFUSE: begin
                if (!key_hit) begin
                    state_nxt = ST_PROG;
                end
            end
            default: state_nxt = ST_OFF;
        endcase
        if (!act_lv) begin
            state_nxt = ST_OFF;                                  // [R2]
        end
        prog_entry = (state_nxt == ST_PROG) && (state_r != ST_PROG);
    end

    // Configuration registers and efuse programming
    always_comb begin
        tx_ctrl_nxt = tx_ctrl_r;
        rx_ctrl_nxt = rx_ctrl_r;
        ef_def_nxt  = ef_def_r;
        fuse_nxt    = fuse_r;
        burn_nxt    = 1'b0;
        if (prog_entry) begin
            tx_ctrl_nxt = TX_CTRL_RST;                           // [R4]
            rx_ctrl_nxt = RX_CTRL_RST;                           // [R4]
            ef_def_nxt  = EF_DEF_RST;                            // [R4]
        end else if (wr_stb) begin
            case (wr_addr)
                ADDR_TX_CTRL: if (acc_cfg) tx_ctrl_nxt = wr_data; // [R11]
                ADDR_RX_CTRL: if (acc_cfg) rx_ctrl_nxt = wr_data; // [R12]
                ADDR_EF_DEF:  if (acc_ef) ef_def_nxt = wr_data;   // [R10] [R13]
                ADDR_EF_TRIG: begin
                    if (acc_ef && wr_data[EFT_FIRE_BIT]) begin   // [R10] [R13]
                        burn_nxt = 1'b1;
                        if (ef_def_r[3:0] <= FUSE_LAST_IDX) begin
                            fuse_nxt[ef_def_r[3:0]] = 1'b1;      // [R15]
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    // Path and antenna outputs follow the next state, gain the current transmit control, mode pin and fuses
    always_comb begin
        rxp_nxt  = (state_nxt == ST_RX);                         // [R6]
        txp_nxt  = (state_nxt == ST_TX);                         // [R7]
        port1_nxt = (rxp_nxt || txp_nxt) && !ant_lv;             // [R16] [R17]
        port2_nxt = (rxp_nxt || txp_nxt) && ant_lv;              // [R16] [R18]
        pout_b   = mode_lv | tx_ctrl_r[TXC_POUTB_BIT];
        if (tx_ctrl_r[TXC_MODE_BIT]) begin
            if (!pout_b) begin
                gain_nxt = fuse_r[FUSE_A_SEL] ? fuse_r[FUSE_A_GAIN_MSB:FUSE_A_GAIN_LSB] : FACTORY_A_GAIN; // [R19]
            end else begin
                gain_nxt = fuse_r[FUSE_B_SEL] ? fuse_r[FUSE_B_GAIN_MSB:FUSE_B_GAIN_LSB] : FACTORY_B_GAIN; // [R19]
            end
        end else if (tx_ctrl_r[TXC_GAIN_MSB:TXC_GAIN_LSB] != 5'h00) begin
            gain_nxt = tx_ctrl_r[TXC_GAIN_MSB:TXC_GAIN_LSB];
        end else begin
            gain_nxt = pout_b ? FACTORY_B_GAIN : FACTORY_A_GAIN;
        end
    end

    // All state registers
    always_ff @(posedge clock) begin
        if (reset) begin
            state_r    <= ST_OFF;
            tx_ctrl_r  <= TX_CTRL_RST;
            rx_ctrl_r  <= RX_CTRL_RST;
            ef_def_r   <= EF_DEF_RST;
            fuse_r     <= '0;
            burn_r     <= 1'b0;
            sck_prev_r <= 1'b0;
            bit_cnt_r  <= 5'h00;
            shift_r    <= 16'h0000;
            rd_sh_r    <= 8'h00;
            miso_r     <= 1'b0;
            miso_oe_r  <= 1'b0;
            rxp_r      <= 1'b0;
            txp_r      <= 1'b0;
            port1_r    <= 1'b0;
            port2_r    <= 1'b0;
            gain_r     <= FACTORY_A_GAIN;
        end else begin
            state_r    <= state_nxt;
            tx_ctrl_r  <= tx_ctrl_nxt;
            rx_ctrl_r  <= rx_ctrl_nxt;
            ef_def_r   <= ef_def_nxt;
            fuse_r     <= fuse_nxt;
            burn_r     <= burn_nxt;
            sck_prev_r <= sck_prev_nxt;
            bit_cnt_r  <= bit_cnt_nxt;
            shift_r    <= shift_nxt;
            rd_sh_r    <= rd_sh_nxt;
            miso_r     <= miso_nxt;
            miso_oe_r  <= miso_oe_nxt;
            rxp_r      <= rxp_nxt;
            txp_r      <= txp_nxt;
            port1_r    <= port1_nxt;
            port2_r    <= port2_nxt;
            gain_r     <= gain_nxt;
        end
    end

    // Output wiring, all from flip-flops
    assign spi_miso            = miso_r;
    assign spi_miso_oe         = miso_oe_r;
    assign rx_path_en          = rxp_r;
    assign lna_en              = rxp_r;
    assign tx_path_en          = txp_r;
    assign pa_en               = txp_r;
    assign first_antenna_port  = port1_r;
    assign second_antenna_port = port2_r;
    assign tx_gain             = gain_r;
    assign efuse_burn          = burn_r;
    assign fem_state           = state_r;

    // Checks on state, register reload, efuse burn, paths, antennas and gain
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_off_when_inactive: assert property (!act_lv |=> state_r == ST_OFF) // [R2]
        else $error("front-end left power-down while inactive");
    a_off_to_program: assert property (state_r == ST_OFF && act_lv |=> state_r == ST_PROG) // [R3]
        else $error("activation did not reach program state");
    a_program_entry_reset: assert property ($changed(state_r) && state_r == ST_PROG |-> // [R4]
        tx_ctrl_r == TX_CTRL_RST && rx_ctrl_r == RX_CTRL_RST && ef_def_r == EF_DEF_RST)
        else $error("registers not reloaded on program entry");
    a_pin_rx_request: assert property (state_r == ST_PROG && act_lv && rx_lv && !tx_lv // [R5]
        && !tx_ctrl_r[TXC_ON_BIT] && !key_hit |=> state_r == ST_RX)
        else $error("receive pin did not select receive state");
    a_rx_paths: assert property (state_r == ST_RX |-> rx_path_en && lna_en && !tx_path_en && !pa_en) // [R6]
        else $error("receive state path enables wrong");
    a_tx_paths: assert property (state_r == ST_TX |-> tx_path_en && pa_en && !rx_path_en && !lna_en) // [R7]
        else $error("transmit state path enables wrong");
    a_efuse_from_prog: assert property ($changed(state_r) && state_r == ST_EFUSE |-> $past(state_r) == ST_PROG) // [R9]
        else $error("efuse state entered from wrong state");
    a_efuse_gated: assert property (burn_r |-> $past(state_r) == ST_EFUSE) // [R13]
        else $error("efuse burn outside efuse state");
    a_ant_isolate: assert property (state_r != ST_RX && state_r != ST_TX // [R16]
        |-> !first_antenna_port && !second_antenna_port)
        else $error("antenna not isolated");
    a_ant_first: assert property ((state_r == ST_RX || state_r == ST_TX) && !$past(ant_lv) // [R17]
        |-> first_antenna_port && !second_antenna_port)
        else $error("low antenna choice wrong port");
    a_ant_second: assert property ((state_r == ST_RX || state_r == ST_TX) && $past(ant_lv) // [R18]
        |-> !first_antenna_port && second_antenna_port)
        else $error("high antenna choice wrong port");
    a_custom_gain: assert property (tx_ctrl_r[TXC_MODE_BIT] && !pout_b && fuse_r[FUSE_A_SEL] // [R19]
        |=> tx_gain == $past(fuse_r[FUSE_A_GAIN_MSB:FUSE_A_GAIN_LSB]))
        else $error("custom preset gain not applied");

endmodule

/* logic/rfsc_pkg.sv */
package rfsc_pkg;

    // Front-end operating states
    typedef enum logic [2:0] {
        ST_OFF,
        ST_PROG,
        ST_EFUSE,
        ST_RX,
        ST_TX
    } rfsc_state_t;

    // Serial frame: command bit, 7-bit address, 8-bit data
    localparam logic [4:0] SPI_FRAME_BITS  = 5'h10;
    localparam logic [4:0] SPI_HDR_BITS    = 5'h08;

    // Register addresses
    localparam logic [6:0] ADDR_TX_CTRL    = 7'h00;
    localparam logic [6:0] ADDR_RX_CTRL    = 7'h01;
    localparam logic [6:0] ADDR_EF_DEF     = 7'h02;
    localparam logic [6:0] ADDR_EF_TRIG    = 7'h03;
    localparam logic [6:0] ADDR_PART       = 7'h14;
    localparam logic [6:0] ADDR_ID_LOW     = 7'h15;
    localparam logic [6:0] ADDR_ID_HIGH    = 7'h16;

    // Transmit control fields
    localparam int         TXC_ON_BIT      = 0;
    localparam int         TXC_MODE_BIT    = 1;
    localparam int         TXC_POUTB_BIT   = 2;
    localparam int         TXC_GAIN_LSB    = 3;
    localparam int         TXC_GAIN_MSB    = 7;

    // Receive control fields
    localparam int         RXC_ON_BIT      = 0;
    localparam int         RXC_KEY_LSB     = 4;
    localparam int         RXC_KEY_MSB     = 7;
    localparam logic [3:0] EFUSE_KEY       = 4'hA;

    // Efuse trigger and bit definition
    localparam int         EFT_FIRE_BIT    = 0;
    localparam logic [3:0] FUSE_LAST_IDX   = 4'hB;

    // Efuse word layout
    localparam int         FUSE_W          = 12;
    localparam int         FUSE_A_SEL      = 0;
    localparam int         FUSE_A_GAIN_LSB = 1;
    localparam int         FUSE_A_GAIN_MSB = 5;
    localparam int         FUSE_B_SEL      = 6;
    localparam int         FUSE_B_GAIN_LSB = 7;
    localparam int         FUSE_B_GAIN_MSB = 11;

    // Reset values
    localparam logic [7:0] TX_CTRL_RST     = 8'h00;
    localparam logic [7:0] RX_CTRL_RST     = 8'h00;
    localparam logic [7:0] EF_DEF_RST      = 8'h00;
    localparam logic [4:0] FACTORY_A_GAIN  = 5'h14;
    localparam logic [4:0] FACTORY_B_GAIN  = 5'h0A;

endpackage

/* logic/rfsc_sync3.sv */
`timescale 1ns/1ps
module rfsc_sync3 #(
    parameter int WIDTH = 8
) (
    input  logic             clock,
    input  logic             reset,
    input  logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level
);

    // Refuse an empty vector
    if (WIDTH < 1) begin : g_chk
        $error("rfsc_sync3 needs WIDTH of at least 1");
    end

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] lvl_r;
    logic [WIDTH-1:0] lvl_nxt;
    logic [WIDTH-1:0] agree;

    // Level follows only where second and third stages agree
    always_comb begin
        agree   = ~(s2_r ^ s3_r);
        lvl_nxt = (s3_r & agree) | (lvl_r & ~agree);
    end

    // Three-stage chain plus filtered level
    always_ff @(posedge clock) begin
        if (reset) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            lvl_r <= '0;
        end else begin
            s1_r  <= async_in;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    assign level = lvl_r;

endmodule

/* sim/rfsc_host_model.sv */
`timescale 1ns/1ps
// Host side of the front-end: the nine dedicated control lines
module rfsc_host_model (
    input  logic clock,
    input  logic spi_miso,
    output logic fem_active_pin,
    output logic rx_request_pin,
    output logic tx_request_pin,
    output logic mode_pin,
    output logic antenna_choice_pin,
    output logic spi_sck,
    output logic spi_csn,
    output logic spi_mosi
);
    // Idle lines: inactive, deselected, serial clock parked low
    initial begin
        fem_active_pin     = 1'h0;
        rx_request_pin     = 1'h0;
        tx_request_pin     = 1'h0;
        mode_pin           = 1'h0;
        antenna_choice_pin = 1'h0;
        spi_sck            = 1'h0;
        spi_csn            = 1'h1;
        spi_mosi           = 1'h0;
    end

    // Pin control; a transmit request masks a receive request
    task automatic set_pins(input logic act, input logic rx, input logic tx, input logic ant, input logic mode);
        @(negedge clock);
        fem_active_pin     = act;
        rx_request_pin     = rx & ~tx;
        tx_request_pin     = tx;
        antenna_choice_pin = ant;
        mode_pin           = mode;
    endtask

    // Mode 0 frame, MSB first, eight clocks per serial clock
    task automatic spi_frame(input logic [15:0] word, output logic [7:0] rd);
        logic [15:0] shift;
        shift = 16'h0000;
        @(negedge clock);
        spi_csn = 1'h0;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi = word[i];
            repeat (4) @(negedge clock);
            spi_sck = 1'h1;
            repeat (4) @(negedge clock);
            shift   = {shift[14:0], spi_miso}; // Late in high phase, data settled
            spi_sck = 1'h0;
        end
        repeat (4) @(negedge clock);
        spi_csn  = 1'h1;
        spi_mosi = ~spi_mosi; // Released line does not keep last bit
        repeat (8) @(negedge clock);
        rd = shift[7:0];
    endtask
endmodule

/* sim/rfsc_core_tb.sv */
`timescale 1ns/1ps
module rfsc_core_tb;
    import rfsc_pkg::*;
    logic        clock;
    logic        reset;
    logic        fem_active_pin;
    logic        rx_request_pin;
    logic        tx_request_pin;
    logic        mode_pin;
    logic        antenna_choice_pin;
    logic        spi_sck;
    logic        spi_csn;
    logic        spi_mosi;
    logic        spi_miso;
    logic        spi_miso_oe;
    logic        rx_path_en;
    logic        lna_en;
    logic        tx_path_en;
    logic        pa_en;
    logic        first_antenna_port;
    logic        second_antenna_port;
    logic [4:0]  tx_gain;
    logic        efuse_burn;
    rfsc_state_t fem_state;
    int          miscompares;
    int          check_count;
    int          burns;

    rfsc_host_model host (.clock(clock), .spi_miso(spi_miso), .fem_active_pin(fem_active_pin),
        .rx_request_pin(rx_request_pin), .tx_request_pin(tx_request_pin), .mode_pin(mode_pin),
        .antenna_choice_pin(antenna_choice_pin), .spi_sck(spi_sck), .spi_csn(spi_csn), .spi_mosi(spi_mosi));

    rfsc_core dut (.clock(clock), .reset(reset), .fem_active_pin(fem_active_pin),
        .rx_request_pin(rx_request_pin), .tx_request_pin(tx_request_pin), .mode_pin(mode_pin),
        .antenna_choice_pin(antenna_choice_pin), .spi_sck(spi_sck), .spi_csn(spi_csn),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .rx_path_en(rx_path_en),
        .lna_en(lna_en), .tx_path_en(tx_path_en), .pa_en(pa_en), .first_antenna_port(first_antenna_port),
        .second_antenna_port(second_antenna_port), .tx_gain(tx_gain), .efuse_burn(efuse_burn),
        .fem_state(fem_state));

    // 25 MHz clock
    initial begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end

    // Count fuse programming pulses, sampled mid-cycle
    always @(negedge clock) begin
        if (efuse_burn === 1'h1) begin
            burns <= burns + 1;
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [6:0] addr, input logic [7:0] data);
        logic [7:0] junk;
        host.spi_frame({1'h1, addr, data}, junk);
    endtask

    task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
        logic [7:0] got;
        host.spi_frame({1'h0, addr, 8'h00}, got);
        check(got, exp);
    endtask

    // Bounded wait for a state, then compare {oe, rx, lna, tx, pa, port1, port2}; oe idle between frames
    task automatic expect_fem(input rfsc_state_t st, input logic [5:0] en);
        int n;
        n = 0;
        repeat (8) @(negedge clock);
        while (fem_state !== st && n < 40) begin
            @(negedge clock);
            n++;
        end
        if (fem_state !== st) begin
            miscompares++;
            tally_and_finish();
        end
        check(8'(fem_state), 8'(st));
        check({1'h0, spi_miso_oe, rx_path_en, lna_en, tx_path_en, pa_en, first_antenna_port, second_antenna_port},
              {2'h0, en});
    endtask

    // Main sequence
    initial begin
        miscompares = 0;
        check_count = 0;
        burns       = 0;
        reset       = 1'h1;
        repeat (20) @(negedge clock);
        reset = 1'h0;
        host.set_pins(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
        expect_fem(ST_OFF, 6'h00);
        check(8'(tx_gain), 8'h14);
        rd_chk(ADDR_TX_CTRL, 8'h00);
        $display("test power_down done");
        host.set_pins(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
        expect_fem(ST_PROG, 6'h00);
        rd_chk(ADDR_PART, 8'h5A);
        rd_chk(ADDR_ID_LOW, 8'h3C);
        rd_chk(ADDR_ID_HIGH, 8'h13);
        reg_wr(ADDR_TX_CTRL, 8'h08);
        rd_chk(ADDR_TX_CTRL, 8'h08);
        check(8'(tx_gain), 8'h01);
        $display("test program done");
        host.set_pins(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
        expect_fem(ST_RX, 6'h32);
        rd_chk(ADDR_PART, 8'h00);
        rd_chk(ADDR_TX_CTRL, 8'h08);
        reg_wr(ADDR_RX_CTRL, 8'hA0);
        host.set_pins(1'h1, 1'h1, 1'h0, 1'h1, 1'h0);
        expect_fem(ST_RX, 6'h31);
        host.set_pins(1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
        expect_fem(ST_TX, 6'h0D);
        host.set_pins(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
        expect_fem(ST_PROG, 6'h00);
        rd_chk(ADDR_TX_CTRL, 8'h00);
        check(8'(tx_gain), 8'h14);
        $display("test pin_control done");
        reg_wr(ADDR_TX_CTRL, 8'h01);
        expect_fem(ST_TX, 6'h0E);
        reg_wr(ADDR_TX_CTRL, 8'h00);
        expect_fem(ST_PROG, 6'h00);
        reg_wr(ADDR_RX_CTRL, 8'h01);
        expect_fem(ST_RX, 6'h32);
        rd_chk(ADDR_RX_CTRL, 8'h01);
        reg_wr(ADDR_RX_CTRL, 8'h00);
        expect_fem(ST_PROG, 6'h00);
        $display("test serial_control done");
        reg_wr(ADDR_EF_DEF, 8'h05);
        reg_wr(ADDR_RX_CTRL, 8'hA0);
        expect_fem(ST_EFUSE, 6'h00);
        rd_chk(ADDR_EF_DEF, 8'h00);
        rd_chk(ADDR_TX_CTRL, 8'h00);
        // Burn A select and the two low bits of A gain
        for (int b = 0; b < 3; b++) begin
            reg_wr(ADDR_EF_DEF, 8'(b));
            reg_wr(ADDR_EF_TRIG, 8'h01);
        end
        rd_chk(ADDR_EF_DEF, 8'h02);
        rd_chk(ADDR_EF_TRIG, 8'h00);
        check(8'(burns), 8'h03);
        reg_wr(ADDR_RX_CTRL, 8'h00);
        expect_fem(ST_PROG, 6'h00);
        reg_wr(ADDR_TX_CTRL, 8'h02);
        check(8'(tx_gain), 8'h03);
        host.set_pins(1'h1, 1'h0, 1'h0, 1'h0, 1'h1);
        repeat (8) @(negedge clock);
        check(8'(tx_gain), 8'h0A);
        // Preset B picked by the register bit alone, mode pin back low
        reg_wr(ADDR_TX_CTRL, 8'h04);
        host.set_pins(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
        repeat (8) @(negedge clock);
        check(8'(tx_gain), 8'(FACTORY_B_GAIN));
        $display("test efuse_presets done");
        tally_and_finish();
    end
endmodule
